// >>> omlp_consts.svh
// Purpose: named constants for the OR / move / load-pointer execute block
// Assumes: included by bare name
// Notes:   offsets are APB byte addresses
`ifndef OMLP_CONSTS_SVH
`define OMLP_CONSTS_SVH

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define OMLP_OPC_OR_LIT    8'h09
`define OMLP_OPC_OR_FILE   6'h04
`define OMLP_OPC_MOVE_FILE 6'h14
`define OMLP_OPC_PTR_HIGH  10'h3B8
`define OMLP_OPC_PTR_LOW   8'hF0
`define OMLP_IDX_LIMIT     8'h5F
`define OMLP_ACC_HIGH      4'hF
`define OMLP_ACC_LOW       4'h0
`define OMLP_BIT_DEST      9
`define OMLP_BIT_ACCESS    8
`define OMLP_BIT_NEG       7
`define OMLP_PTR_COUNT     3

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define OMLP_OFF_CTRL      12'h000
`define OMLP_OFF_WORK      12'h004
`define OMLP_OFF_BANK      12'h008
`define OMLP_OFF_FLAGS     12'h00C
`define OMLP_OFF_PTR0      12'h010
`define OMLP_OFF_DADDR     12'h01C
`define OMLP_OFF_DDATA     12'h020
`define OMLP_CTRL_RUN      0
`define OMLP_CTRL_EXT      1
`define OMLP_FLAG_Z        0
`define OMLP_FLAG_N        1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OMLP_RST_BYTE      8'h00
`define OMLP_RST_NIB       4'h0
`define OMLP_RST_ADDR      12'h000
`define OMLP_RST_WORD      32'h00000000
`define OMLP_RST_FLAGS     2'h0
`define OMLP_RST_INSTR     16'h0000

`endif

// >>> omlp_pkg.sv
// Purpose: types for the OR / move / load-pointer execute block
// Assumes: nothing
// Notes:   phase codes are Gray along decode-read-process-write
package omlp_pkg;

    typedef enum logic [1:0] {
        PH_DECODE  = 2'h0,
        PH_READ    = 2'h1,
        PH_PROCESS = 2'h3,
        PH_WRITE   = 2'h2
    } omlp_phase_t;

    typedef enum logic [2:0] {
        OP_NONE      = 3'h0,
        OP_OR_LIT    = 3'h1,
        OP_OR_FILE   = 3'h2,
        OP_MOVE_FILE = 3'h3,
        OP_PTR_HIGH  = 3'h4,
        OP_PTR_LOW   = 3'h5
    } omlp_op_t;

endpackage

// >>> omlp_file_ram.sv
// Purpose: 4096-byte file register space, one write and two read ports
// Assumes: reads are registered, one cycle after the address
// Notes:   contents are not reset
`timescale 1ns/1ps
module omlp_file_ram (
    input  wire logic        clk_i,
    input  wire logic        ce_i,
    input  wire logic        we_i,
    input  wire logic [11:0] waddr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [11:0] raddr_a_i,
    output logic      [7:0]  rdata_a_o,
    input  wire logic [11:0] raddr_b_i,
    output logic      [7:0]  rdata_b_o
);

    logic [7:0] mem [4096];

    always_ff @(posedge clk_i) begin
        if (ce_i && we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            rdata_a_o <= mem[raddr_a_i];
            rdata_b_o <= mem[raddr_b_i];
        end
    end

endmodule

// >>> omlp_exec.sv
// Purpose: execute OR-literal, OR-file, move-file and load-pointer words
// Assumes: instruction words come from same-clock fetch logic
// Notes:   software writes to core state take effect only while halted
//
// Notes on behaviour
// - OR literal into work, set N and Z
// - OR work with file, flags N Z only
// - dest bit 0 to work, 1 to file
// - access bit 0 access bank, 1 uses bank_select
// - extended set, f up to 5Fh indexed
// - OR-file: decode, read, process, write phases
// - load 12-bit literal into pointer 0..2, flags kept
// - two-word load-pointer decode
// - move file to destination, N Z, same four phases
`timescale 1ns/1ps
`include "omlp_consts.svh"
module omlp_exec (
    input  wire logic        CLOCK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        CE_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic             PREADY_O,
    output logic      [31:0] PRDATA_O,
    output logic             PSLVERR_O,
    input  wire logic [15:0] INSTR_I,
    input  wire logic        INSTR_VALID_I,
    output logic             INSTR_READY_O,
    output logic      [7:0]  WORK_O,
    output logic      [1:0]  FLAGS_O
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    omlp_pkg::omlp_phase_t phase_q;
    omlp_pkg::omlp_op_t    op_q;
    logic [15:0] ir_q;
    logic [11:0] addr_q;
    logic [7:0]  result_q;
    logic        ready_q;
    logic        ptr_pend_q;
    logic [1:0]  ptr_sel_q;
    logic        run_q;
    logic        ext_q;
    logic [7:0]  work_q;
    logic [3:0]  bank_q;
    logic [1:0]  flags_q;
    logic [11:0] daddr_q;
    logic [11:0] ptr_w [`OMLP_PTR_COUNT];
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [7:0]  file_rdata;
    logic [7:0]  dbg_rdata;
    logic        apb_wr;
    logic        sw_wr;
    logic        core_wr;
    logic        take;
    logic        in_write;
    logic        to_file;
    logic        flag_op;
    logic        ram_we;
    logic [11:0] ram_waddr;
    logic [7:0]  ram_wdata;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    function automatic omlp_pkg::omlp_op_t decode_op(input logic [15:0] w,
                                                    input logic pend);
        decode_op = omlp_pkg::OP_NONE;
        if (pend && w[15:8] == `OMLP_OPC_PTR_LOW) begin
            decode_op = omlp_pkg::OP_PTR_LOW;
        end else if (w[15:8] == `OMLP_OPC_OR_LIT) begin
            decode_op = omlp_pkg::OP_OR_LIT;
        end else if (w[15:10] == `OMLP_OPC_OR_FILE) begin
            decode_op = omlp_pkg::OP_OR_FILE;
        end else if (w[15:10] == `OMLP_OPC_MOVE_FILE) begin
            decode_op = omlp_pkg::OP_MOVE_FILE;
        end else if (w[15:6] == `OMLP_OPC_PTR_HIGH) begin
            decode_op = omlp_pkg::OP_PTR_HIGH;
        end
    endfunction

    function automatic logic [11:0] file_addr(input logic [15:0] w,
                                              input logic [3:0] bank,
                                              input logic ext,
                                              input logic [11:0] base);
        file_addr = {bank, w[7:0]};
        if (!w[`OMLP_BIT_ACCESS]) begin
            if (w[7:0] > `OMLP_IDX_LIMIT) begin
                file_addr = {`OMLP_ACC_HIGH, w[7:0]};
            end else if (ext) begin
                file_addr = base + {`OMLP_ACC_LOW, w[7:0]};
            end else begin
                file_addr = {`OMLP_ACC_LOW, w[7:0]};
            end
        end
    endfunction

    assign apb_wr   = PSEL_I & PENABLE_I & PWRITE_I & pready_q;
    assign sw_wr    = apb_wr & ~run_q;
    assign take     = ready_q & INSTR_VALID_I;
    assign in_write = (phase_q == omlp_pkg::PH_WRITE);
    assign to_file  = ir_q[`OMLP_BIT_DEST];
    assign flag_op  = (op_q == omlp_pkg::OP_OR_LIT) | (op_q == omlp_pkg::OP_OR_FILE)
                    | (op_q == omlp_pkg::OP_MOVE_FILE);
    assign core_wr  = in_write & to_file & flag_op & (op_q != omlp_pkg::OP_OR_LIT);

    // ----------------------------------------------------------------
    // phase sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            phase_q    <= omlp_pkg::PH_DECODE;
            op_q       <= omlp_pkg::OP_NONE;
            ir_q       <= `OMLP_RST_INSTR;
            addr_q     <= `OMLP_RST_ADDR;
            ready_q    <= 1'b0;
        end else if (CE_I) begin
            unique case (phase_q)
                omlp_pkg::PH_DECODE: begin
                    if (take) begin
                        ir_q    <= INSTR_I;
                        op_q    <= decode_op(INSTR_I, ptr_pend_q);
                        addr_q  <= file_addr(INSTR_I, bank_q, ext_q, ptr_w[2]);
                        ready_q <= 1'b0;
                        phase_q <= omlp_pkg::PH_READ;
                    end else begin
                        ready_q <= run_q;
                    end
                end
                omlp_pkg::PH_READ: begin
                    phase_q <= omlp_pkg::PH_PROCESS;
                end
                omlp_pkg::PH_PROCESS: begin
                    phase_q <= omlp_pkg::PH_WRITE;
                end
                omlp_pkg::PH_WRITE: begin
                    phase_q <= omlp_pkg::PH_DECODE;
                    ready_q <= run_q;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // combine data
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            result_q <= `OMLP_RST_BYTE;
        end else if (CE_I && phase_q == omlp_pkg::PH_PROCESS) begin
            unique case (op_q)
                omlp_pkg::OP_OR_LIT:    result_q <= work_q | ir_q[7:0];
                omlp_pkg::OP_OR_FILE:   result_q <= work_q | file_rdata;
                omlp_pkg::OP_MOVE_FILE: result_q <= file_rdata;
                default:                result_q <= result_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // two-word pointer load tracking
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ptr_pend_q <= 1'b0;
            ptr_sel_q  <= 2'h0;
        end else if (CE_I) begin
            if (in_write && op_q == omlp_pkg::OP_PTR_HIGH) begin
                ptr_pend_q <= 1'b1;
                ptr_sel_q  <= ir_q[5:4];
            end else if (in_write) begin
                ptr_pend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // file select pointers
    // ----------------------------------------------------------------
    for (genvar i = 0; i < `OMLP_PTR_COUNT; i++) begin : g_ptr
        logic [11:0] p_q;
        logic        hi_w;
        logic        lo_w;
        assign hi_w = in_write && op_q == omlp_pkg::OP_PTR_HIGH && ir_q[5:4] == i;
        assign lo_w = in_write && op_q == omlp_pkg::OP_PTR_LOW && ptr_sel_q == i;
        always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
                p_q <= `OMLP_RST_ADDR;
            end else if (CE_I) begin
                if (hi_w) begin
                    p_q[11:8] <= ir_q[3:0];
                end else if (lo_w) begin
                    p_q[7:0] <= ir_q[7:0];
                end else if (sw_wr && hit(PADDR_I, `OMLP_OFF_PTR0 + 12'(4 * i))) begin
                    p_q <= PWDATA_I[11:0];
                end
            end
        end
        assign ptr_w[i] = p_q;
    end

    // ----------------------------------------------------------------
    // working register and flags
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            work_q <= `OMLP_RST_BYTE;
        end else if (CE_I) begin
            if (in_write && flag_op && (op_q == omlp_pkg::OP_OR_LIT || !to_file)) begin
                work_q <= result_q;
            end else if (sw_wr && hit(PADDR_I, `OMLP_OFF_WORK)) begin
                work_q <= PWDATA_I[7:0];
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            flags_q <= `OMLP_RST_FLAGS;
        end else if (CE_I) begin
            if (in_write && flag_op) begin
                flags_q[`OMLP_FLAG_N] <= result_q[`OMLP_BIT_NEG];
                flags_q[`OMLP_FLAG_Z] <= (result_q == `OMLP_RST_BYTE);
            end else if (sw_wr && hit(PADDR_I, `OMLP_OFF_FLAGS)) begin
                flags_q <= PWDATA_I[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            run_q <= 1'b0;
            ext_q <= 1'b0;
        end else if (CE_I && apb_wr && hit(PADDR_I, `OMLP_OFF_CTRL)) begin
            run_q <= PWDATA_I[`OMLP_CTRL_RUN];
            ext_q <= PWDATA_I[`OMLP_CTRL_EXT];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            bank_q  <= `OMLP_RST_NIB;
            daddr_q <= `OMLP_RST_ADDR;
        end else if (CE_I && sw_wr) begin
            if (hit(PADDR_I, `OMLP_OFF_BANK)) begin
                bank_q <= PWDATA_I[3:0];
            end
            if (hit(PADDR_I, `OMLP_OFF_DADDR)) begin
                daddr_q <= PWDATA_I[11:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // file register space
    // ----------------------------------------------------------------
    assign ram_we    = core_wr | (sw_wr & hit(PADDR_I, `OMLP_OFF_DDATA));
    assign ram_waddr = core_wr ? addr_q : daddr_q;
    assign ram_wdata = core_wr ? result_q : PWDATA_I[7:0];

    omlp_file_ram u_ram (
        .clk_i     (CLOCK_I),
        .ce_i      (CE_I),
        .we_i      (ram_we),
        .waddr_i   (ram_waddr),
        .wdata_i   (ram_wdata),
        .raddr_a_i (addr_q),
        .rdata_a_o (file_rdata),
        .raddr_b_i (daddr_q),
        .rdata_b_o (dbg_rdata)
    );

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pready_q  <= 1'b0;
            prdata_q  <= `OMLP_RST_WORD;
            pslverr_q <= 1'b0;
        end else if (CE_I) begin
            pready_q  <= PSEL_I & ~PENABLE_I;
            if (PSEL_I && !PENABLE_I) begin
                pslverr_q <= 1'b0;
                prdata_q  <= `OMLP_RST_WORD;
                if (hit(PADDR_I, `OMLP_OFF_CTRL)) begin
                    prdata_q[`OMLP_CTRL_RUN] <= run_q;
                    prdata_q[`OMLP_CTRL_EXT] <= ext_q;
                end else if (hit(PADDR_I, `OMLP_OFF_WORK)) begin
                    prdata_q[7:0] <= work_q;
                end else if (hit(PADDR_I, `OMLP_OFF_BANK)) begin
                    prdata_q[3:0] <= bank_q;
                end else if (hit(PADDR_I, `OMLP_OFF_FLAGS)) begin
                    prdata_q[1:0] <= flags_q;
                end else if (hit(PADDR_I, `OMLP_OFF_PTR0)) begin
                    prdata_q[11:0] <= ptr_w[0];
                end else if (hit(PADDR_I, `OMLP_OFF_PTR0 + 12'h004)) begin
                    prdata_q[11:0] <= ptr_w[1];
                end else if (hit(PADDR_I, `OMLP_OFF_PTR0 + 12'h008)) begin
                    prdata_q[11:0] <= ptr_w[2];
                end else if (hit(PADDR_I, `OMLP_OFF_DADDR)) begin
                    prdata_q[11:0] <= daddr_q;
                end else if (hit(PADDR_I, `OMLP_OFF_DDATA)) begin
                    prdata_q[7:0] <= dbg_rdata;
                end else begin
                    pslverr_q <= 1'b1;
                end
            end
        end
    end

    assign PREADY_O      = pready_q;
    assign PRDATA_O      = prdata_q;
    assign PSLVERR_O     = pslverr_q;
    assign INSTR_READY_O = ready_q;
    assign WORK_O        = work_q;
    assign FLAGS_O       = flags_q;

endmodule

// >>> omlp_exec_monitor.sv
// Purpose: port-level checks for the OR / move / load-pointer execute block
// Assumes: CE_I high whenever the checked sequences run
// Notes:   bound to omlp_exec below
`timescale 1ns/1ps
`include "omlp_consts.svh"
module omlp_exec_monitor (
    input wire logic        CLOCK_I,
    input wire logic        RESET_N_I,
    input wire logic        CE_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PREADY_O,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PSLVERR_O,
    input wire logic [15:0] INSTR_I,
    input wire logic        INSTR_VALID_I,
    input wire logic        INSTR_READY_O,
    input wire logic [7:0]  WORK_O,
    input wire logic [1:0]  FLAGS_O
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    wire logic is_lit  = INSTR_I[15:8] == `OMLP_OPC_OR_LIT;
    wire logic is_file = INSTR_I[15:10] == `OMLP_OPC_OR_FILE
                         || INSTR_I[15:10] == `OMLP_OPC_MOVE_FILE;
    wire logic is_ptr  = INSTR_I[15:6] == `OMLP_OPC_PTR_HIGH
                         || INSTR_I[15:8] == `OMLP_OPC_PTR_LOW;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_take;
        INSTR_VALID_I && INSTR_READY_O && CE_I;
    endsequence
    sequence s_setup;
        PSEL_I && !PENABLE_I && CE_I;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_or_lit;
        logic [7:0] k;
        logic [7:0] w;
        s_take ##0 (is_lit, k = INSTR_I[7:0], w = WORK_O) |-> ##4 WORK_O == (w | k);
    endproperty
    property p_or_bits;
        logic [7:0] w;
        s_take ##0 (INSTR_I[15:10] == `OMLP_OPC_OR_FILE && !INSTR_I[9], w = WORK_O)
            |-> ##4 (WORK_O & w) == w;
    endproperty

    a_apb_ready: assert property (s_setup |=> PREADY_O)
        else $error("ready missing after setup");
    a_ready_single: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_err_zero: assert property (PREADY_O && PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
        else $error("error read returned data");
    a_or_literal: assert property (p_or_lit)
        else $error("or literal result wrong");
    a_or_sets: assert property (p_or_bits)
        else $error("or file cleared a work bit");
    a_busy_phases: assert property (s_take |=> !INSTR_READY_O [*3])
        else $error("word taken during phases");
    a_flags_kept: assert property (s_take ##0 is_ptr |=> $stable(FLAGS_O) [*4])
        else $error("pointer load changed flags");
    a_dest_file: assert property (s_take ##0 (is_file && INSTR_I[9]) |=> $stable(WORK_O) [*4])
        else $error("file destination changed work");
    a_flags_match: assert property (s_take ##0 (is_lit || (is_file && !INSTR_I[9]))
        |-> ##4 FLAGS_O == {WORK_O[7], WORK_O == 8'h00})
        else $error("flags disagree with result");
endmodule

bind omlp_exec omlp_exec_monitor mon_u (
    .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .INSTR_I(INSTR_I),
    .INSTR_VALID_I(INSTR_VALID_I), .INSTR_READY_O(INSTR_READY_O), .WORK_O(WORK_O),
    .FLAGS_O(FLAGS_O)
);

// >>> omlp_exec_tb.sv
// Purpose: self-checking bench for the OR / move / load-pointer execute block
// Assumes: APB slave may insert wait states; every transfer waits for ready
// Notes:   core state is loaded while halted, then one word runs per row
`timescale 1ns/1ps
`include "omlp_consts.svh"
module omlp_exec_tb;
    typedef struct packed {
        logic [15:0] wd;
        logic        ext;
        logic [3:0]  bank;
        logic [7:0]  wk;
        logic [11:0] fa;
        logic [7:0]  fi;
        logic [7:0]  ewk;
        logic [7:0]  efi;
        logic [1:0]  efl;
    } omlp_row_t;

    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [15:0] instr;
    logic        ivalid;
    logic        iready;
    logic [7:0]  work;
    logic [1:0]  flags;
    logic [31:0] rdv;
    logic        errv;
    int          mismatches;
    int          n_compared;
    int          cycles;
    omlp_row_t   r;
    logic [11:0] kv [3] = '{12'h3AB, 12'hF5A, 12'h7C1};
    omlp_row_t   rows [8] = '{
        '{16'h0935, 1'b0, 4'h0, 8'h9A, 12'h000, 8'h00, 8'hBF, 8'h00, 2'h2},
        '{16'h0900, 1'b0, 4'h0, 8'h00, 12'h000, 8'h00, 8'h00, 8'h00, 2'h1},
        '{16'h1140, 1'b0, 4'h3, 8'h91, 12'h340, 8'h13, 8'h93, 8'h13, 2'h2},
        '{16'h1280, 1'b0, 4'h0, 8'h30, 12'hF80, 8'h0F, 8'h30, 8'h3F, 2'h0},
        '{16'h1220, 1'b0, 4'h0, 8'h00, 12'h020, 8'h00, 8'h00, 8'h00, 2'h1},
        '{16'h51FF, 1'b0, 4'h5, 8'hFF, 12'h5FF, 8'h22, 8'h22, 8'h22, 2'h0},
        '{16'h5210, 1'b1, 4'h0, 8'h55, 12'h210, 8'h80, 8'h55, 8'h80, 2'h2},
        '{16'h5060, 1'b1, 4'h0, 8'h77, 12'hF60, 8'h00, 8'h00, 8'h00, 2'h1}
    };

    omlp_exec dut_u (
        .CLOCK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .INSTR_I(instr), .INSTR_VALID_I(ivalid),
        .INSTR_READY_O(iready), .WORK_O(work), .FLAGS_O(flags)
    );

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // bus and instruction tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp, "register read");
    endtask

    task automatic exec(input logic [15:0] w);
        instr <= w;
        ivalid <= 1'b1;
        @(posedge clk);
        while (iready !== 1'b1) @(posedge clk);
        ivalid <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        instr = 16'h0000;
        ivalid = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({20'h0, work, flags, iready, pready}, 32'h0, "reset outputs");
        rdchk(`OMLP_OFF_PTR0, 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        chk({31'h0, errv}, 32'h1, "unmapped error");
        chk(rdv, 32'h0, "unmapped data");
        wr(`OMLP_OFF_CTRL, 32'h1);
        wr(`OMLP_OFF_WORK, 32'h5A);
        rdchk(`OMLP_OFF_WORK, 32'h0);
        wr(`OMLP_OFF_CTRL, 32'h0);
        wr(12'h018, 32'h200);
        foreach (rows[i]) begin
            r = rows[i];
            wr(`OMLP_OFF_WORK, {24'h0, r.wk});
            wr(`OMLP_OFF_BANK, {28'h0, r.bank});
            wr(`OMLP_OFF_DADDR, {20'h0, r.fa});
            wr(`OMLP_OFF_DDATA, {24'h0, r.fi});
            wr(`OMLP_OFF_CTRL, {30'h0, r.ext, 1'b1});
            exec(r.wd);
            chk({24'h0, work}, {24'h0, r.ewk}, "work");
            chk({30'h0, flags}, {30'h0, r.efl}, "flags");
            wr(`OMLP_OFF_CTRL, 32'h0);
            rdchk(`OMLP_OFF_DDATA, {24'h0, r.efi});
        end
        wr(`OMLP_OFF_CTRL, 32'h1);
        for (int s = 0; s < 3; s++) begin
            exec({10'h3B8, s[1:0], kv[s][11:8]});
            rdchk(12'h010 + 12'(s * 4), {20'h0, kv[s][11:8], 8'h00});
            exec({8'hF0, kv[s][7:0]});
            rdchk(12'h010 + 12'(s * 4), {20'h0, kv[s]});
            chk({30'h0, flags}, 32'h1, "flags kept");
        end
        exec(16'hEE3F);
        exec(16'hF0FF);
        rdchk(12'h018, {20'h0, kv[2]});
        rdchk(12'h010, {20'h0, kv[0]});
        ce <= 1'b0;
        exec(16'h0935);
        chk({22'h0, work, flags}, 32'h1, "frozen by clock enable");
        ce <= 1'b1;
        exec(16'h0935);
        chk({24'h0, work}, 32'h35, "work");
        chk({30'h0, flags}, 32'h0, "flags");
        rst_n <= 1'b0;
        @(posedge clk);
        chk({20'h0, work, flags, iready, pready}, 32'h0, "second reset");
        rst_n <= 1'b1;
        @(posedge clk);
        rdchk(`OMLP_OFF_PTR0 + 12'h008, 32'h0);
        rdchk(`OMLP_OFF_CTRL, 32'h0);
        wrap_up();
    end
endmodule
